// >>> rtl/erasc_ctrl.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module erasc_ctrl #(
  parameter int unsigned BASE_CYCLES = erasc_pkg::BASE_CYCLES_DEF
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [erasc_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [erasc_pkg::SRC_W-1:0] EVT_FLAG_I,
  input wire logic FIFO_EMPTY_I,
  output logic IRQ_PIN_FIRST_O,
  output logic IRQ_PIN_FIRST_OE_O,
  output logic IRQ_PIN_SECOND_O,
  output logic IRQ_PIN_SECOND_OE_O,
  output logic SLEEP_O,
  output logic [3:0] RATE_EXP_O,
  output logic SAMPLE_TICK_O,
  output logic [erasc_pkg::SRC_W-1:0] FUNC_RUN_O,
  output logic FIFO_BLOCK_O
);
  import erasc_pkg::*;

  logic [7:0] sleep_count_r;
  logic [7:0] primary_r;
  logic [7:0] secondary_r;
  logic [7:0] wake_ctl_r;
  logic [7:0] int_en_r;
  logic [7:0] routing_r;
  logic [2:0] mag_ths_cfg_r;
  logic [2:0] mag_vec_cfg_r;
  logic [7:0] mode_cfg_r;
  erasc_mode_t mode_r;
  erasc_mode_t mode_nxt;
  logic [7:0] steps_r;
  logic aslp_flag_r;
  logic gate_err_r;
  logic first_act_r;
  logic second_act_r;
  logic [31:0] prdata_r;
  logic [3:0] rate_exp_r;
  logic tick_r;
  logic [SRC_W-1:0] run_r;
  logic first_out_r;
  logic first_oe_r;
  logic second_out_r;
  logic second_oe_r;

  logic [7:0] idx;
  logic hit;
  logic acc;
  logic wr;
  logic mode_read;
  logic [7:0] rd_val;
  logic [SRC_W-1:0] flags_w;
  logic [SRC_W-1:0] en_w;
  logic [SRC_W-1:0] rt_w;
  logic [SRC_W-1:0] wk_w;
  logic [SRC_W-1:0] run_w;
  logic [SRC_W-1:0] eff_w;
  logic restart_w;
  logic wake_w;
  logic sleep_en;
  logic go_sleep;
  logic transition;
  logic first_nxt;
  logic second_nxt;

  erasc_rate_if rif();

  erasc_rate_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .rt(rif.timer)
  );

  function automatic logic reg_mapped(input logic [7:0] i);
    logic m;
    m = 1'b0;
    if (i == REG_SYSTEM_MODE || i == REG_INT_SOURCE || i == REG_SLEEP_COUNT ||
        i == REG_PRIMARY || i == REG_SECONDARY || i == REG_WAKE_ENABLE ||
        i == REG_INT_ENABLE || i == REG_PIN_ROUTING ||
        i == REG_MAG_THS_CFG || i == REG_MODE_CFG || i == REG_MAG_VEC_CFG) begin
      m = 1'b1;
    end
    return m;
  endfunction

  // returns {oe, out}; open drain only ever pulls the line low
  function automatic logic [1:0] pin_drive(input logic act, input logic pol,
                                           input logic od);
    logic lvl;
    lvl = act ? pol : !pol;
    return od ? {!lvl, 1'b0} : {1'b1, lvl};
  endfunction

  // bus decode
  assign idx = PADDR_I[9:2];
  assign hit = reg_mapped(idx) && PADDR_I[1:0] == 2'b00 &&
               PADDR_I[ADDR_W-1:10] == '0;
  assign acc = PSEL_I && PENABLE_I;
  assign wr = acc && PWRITE_I && hit;
  assign mode_read = acc && !PWRITE_I && hit && idx == REG_SYSTEM_MODE;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc && !reg_mapped(idx) ? 1'b1 :
                     acc && !hit;
  assign PRDATA_O = prdata_r;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sleep_count_r <= REG_RESET;
      primary_r <= REG_RESET;
      secondary_r <= REG_RESET;
      wake_ctl_r <= REG_RESET;
      int_en_r <= REG_RESET;
      routing_r <= REG_RESET;
      mag_ths_cfg_r <= REG_RESET[2:0];
      mag_vec_cfg_r <= REG_RESET[2:0];
      mode_cfg_r <= REG_RESET;
    end else if (wr) begin
      unique case (idx)
        REG_SLEEP_COUNT: sleep_count_r <= PWDATA_I[7:0];
        REG_PRIMARY: primary_r <= PWDATA_I[7:0];
        REG_SECONDARY: secondary_r <= PWDATA_I[7:0];
        REG_WAKE_ENABLE: wake_ctl_r <= PWDATA_I[7:0];
        REG_INT_ENABLE: int_en_r <= PWDATA_I[7:0];
        REG_PIN_ROUTING: routing_r <= PWDATA_I[7:0];
        REG_MAG_THS_CFG: mag_ths_cfg_r <= PWDATA_I[2:0];
        REG_MAG_VEC_CFG: mag_vec_cfg_r <= PWDATA_I[2:0];
        REG_MODE_CFG: mode_cfg_r <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      REG_SYSTEM_MODE: rd_val = {gate_err_r, 5'h00, mode_r};
      REG_INT_SOURCE: rd_val = eff_w[7:0];
      REG_SLEEP_COUNT: rd_val = sleep_count_r;
      REG_PRIMARY: rd_val = primary_r;
      REG_SECONDARY: rd_val = secondary_r;
      REG_WAKE_ENABLE: rd_val = wake_ctl_r;
      REG_INT_ENABLE: rd_val = int_en_r;
      REG_PIN_ROUTING: rd_val = routing_r;
      REG_MAG_THS_CFG: rd_val = {eff_w[IDX_MAG_THRESHOLD], 4'h0, mag_ths_cfg_r};
      REG_MAG_VEC_CFG: rd_val = {eff_w[IDX_MAG_MAGNITUDE], 4'h0, mag_vec_cfg_r};
      REG_MODE_CFG: rd_val = {mode_cfg_r[7:1], eff_w[IDX_MAGNETIC]};
      default: rd_val = 8'h00;
    endcase
  end

  // data is captured in the setup phase so the read port stays registered
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I) begin
      prdata_r <= hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // source vectors
  always_comb begin
    flags_w = EVT_FLAG_I;
    flags_w[IDX_SLEEPWAKE] = aslp_flag_r;
    en_w = {mag_ths_cfg_r[CFG_EN_BIT], mag_vec_cfg_r[CFG_EN_BIT],
            mode_cfg_r[CFG_EN_BIT], int_en_r};
    rt_w = {mag_ths_cfg_r[CFG_ROUTE_BIT], mag_vec_cfg_r[CFG_ROUTE_BIT],
            mode_cfg_r[CFG_ROUTE_BIT], routing_r};
    wk_w = '0;
    wk_w[IDX_TRANSIENT] = wake_ctl_r[WK_TRANS_BIT];
    wk_w[IDX_ORIENT] = wake_ctl_r[WK_ORIENT_BIT];
    wk_w[IDX_TAP] = wake_ctl_r[WK_TAP_BIT];
    wk_w[IDX_FALL_MOTION] = wake_ctl_r[WK_FALL_BIT];
    wk_w[IDX_ACCEL_MAG] = wake_ctl_r[WK_AMAG_BIT];
    wk_w[IDX_MAGNETIC] = mode_cfg_r[CFG_WAKE_BIT];
    wk_w[IDX_MAG_MAGNITUDE] = mag_vec_cfg_r[CFG_WAKE_BIT];
    wk_w[IDX_MAG_THRESHOLD] = mag_ths_cfg_r[CFG_WAKE_BIT];
    // in sleep, wake-capable functions without a wake bit are parked
    run_w = mode_r == MODE_SLEEP ? ~(WAKE_MASK & ~wk_w) : '1;
  end

  assign eff_w = flags_w & en_w & run_w;
  assign restart_w = |(eff_w & RESTART_MASK);
  assign wake_w = |(flags_w & en_w & wk_w & WAKE_MASK);
  assign sleep_en = secondary_r[SEC_SLEEP_EN_BIT];
  assign go_sleep = mode_r == MODE_WAKE && sleep_en && !restart_w &&
                    steps_r == sleep_count_r;
  assign transition = mode_nxt != mode_r;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_WAKE: begin
        if (go_sleep) begin
          mode_nxt = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (wake_w || !sleep_en) begin
          mode_nxt = MODE_WAKE;
        end
      end
      default: mode_nxt = MODE_WAKE;
    endcase
  end

  // the buffer gate never holds the mode back, it only blocks intake
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      mode_r <= MODE_WAKE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // rate control towards the timer
  assign rif.rate_exp = mode_r == MODE_SLEEP ?
    erasc_rate_exp({1'b1, primary_r[PRI_SLEEP_RATE_LSB +: 2]}) :
    erasc_rate_exp(primary_r[PRI_WAKE_RATE_LSB +: 3]);
  assign rif.hybrid = mode_cfg_r[MODE_HYBRID_BIT];
  assign rif.restart = restart_w || mode_r != MODE_WAKE || !sleep_en;

  // inactivity count in steps, saturating
  always_ff @(posedge CLK_I) begin
    if (RESET_I || rif.restart) begin
      steps_r <= 8'h00;
    end else if (rif.step && steps_r != 8'hff) begin
      steps_r <= steps_r + 8'h01;
    end
  end

  // a transition in the same cycle as the clearing read wins
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      aslp_flag_r <= 1'b0;
    end else if (transition && int_en_r[IDX_SLEEPWAKE]) begin
      aslp_flag_r <= 1'b1;
    end else if (mode_read) begin
      aslp_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      gate_err_r <= 1'b0;
    end else if (transition && wake_ctl_r[WK_GATE_BIT]) begin
      gate_err_r <= 1'b1;
    end else if (FIFO_EMPTY_I) begin
      gate_err_r <= 1'b0;
    end
  end

  // pins
  assign first_nxt = |(eff_w & rt_w);
  assign second_nxt = |(eff_w & ~rt_w);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      first_act_r <= 1'b0;
      second_act_r <= 1'b0;
      // push-pull, active low by default: the idle pin sits high
      {first_oe_r, first_out_r} <= 2'b11;
      {second_oe_r, second_out_r} <= 2'b11;
    end else begin
      first_act_r <= first_nxt;
      second_act_r <= second_nxt;
      {first_oe_r, first_out_r} <= pin_drive(first_nxt,
        wake_ctl_r[WK_POL_BIT], wake_ctl_r[WK_OD_BIT]);
      {second_oe_r, second_out_r} <= pin_drive(second_nxt,
        wake_ctl_r[WK_POL_BIT], wake_ctl_r[WK_OD_BIT]);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rate_exp_r <= 4'h0;
      tick_r <= 1'b0;
      run_r <= '1;
    end else begin
      rate_exp_r <= rif.rate_exp;
      tick_r <= rif.sample_tick;
      run_r <= run_w;
    end
  end

  assign IRQ_PIN_FIRST_O = first_out_r;
  assign IRQ_PIN_FIRST_OE_O = first_oe_r;
  assign IRQ_PIN_SECOND_O = second_out_r;
  assign IRQ_PIN_SECOND_OE_O = second_oe_r;
  assign SLEEP_O = mode_r == MODE_SLEEP;
  assign RATE_EXP_O = rate_exp_r;
  assign SAMPLE_TICK_O = tick_r;
  assign FUNC_RUN_O = run_r;
  assign FIFO_BLOCK_O = gate_err_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  chk_route_first: assert property (
    |(eff_w & rt_w) |=> first_act_r && !$past(second_nxt) == !second_act_r)
    else $error("routed source did not reach the first pin");
  chk_route_second: assert property (
    |(eff_w & ~rt_w) |=> second_act_r)
    else $error("routed source did not reach the second pin");
  chk_mag_route: assert property (
    eff_w[IDX_MAG_THRESHOLD] && mag_ths_cfg_r[CFG_ROUTE_BIT] &&
    !(|(eff_w[9:0])) |=> first_act_r && !second_act_r)
    else $error("magnetic threshold routing ignored its own bit");
  chk_pin_idle: assert property (
    !(|eff_w) |=> !first_act_r && !second_act_r)
    else $error("pin asserted with no enabled flag");
  chk_pin_level: assert property (
    !wake_ctl_r[WK_OD_BIT] && $stable(wake_ctl_r) ##1 first_act_r |->
    IRQ_PIN_FIRST_OE_O &&
    IRQ_PIN_FIRST_O == $past(wake_ctl_r[WK_POL_BIT]))
    else $error("first pin level does not follow polarity");
  chk_restart_clear: assert property (
    restart_w && mode_r == MODE_WAKE |=>
    steps_r == 8'h00 && mode_r == $past(mode_r))
    else $error("restart event did not clear the sleep counter");
  chk_enter_sleep: assert property (
    mode_r == MODE_WAKE && sleep_en && !restart_w &&
    steps_r == sleep_count_r |=> mode_r == MODE_SLEEP)
    else $error("inactivity limit reached without entering sleep");
  chk_wake_event: assert property (
    mode_r == MODE_SLEEP && wake_w |=> mode_r == MODE_WAKE ##1
    steps_r == 8'h00 || restart_w)
    else $error("enabled wake event did not wake");
  chk_mode_irq: assert property (
    transition && int_en_r[IDX_SLEEPWAKE] |=> aslp_flag_r [*2] or
    (aslp_flag_r ##1 $past(mode_read)))
    else $error("mode transition did not raise its flag");
  chk_gate_hold: assert property (
    gate_err_r && !FIFO_EMPTY_I |=> gate_err_r && FIFO_BLOCK_O)
    else $error("gate error dropped before the buffer emptied");
  chk_bypass: assert property (
    mode_r == MODE_SLEEP && !wake_ctl_r[WK_TRANS_BIT] |=>
    !FUNC_RUN_O[IDX_TRANSIENT] && FUNC_RUN_O[IDX_SAMPLE_READY])
    else $error("parked function left running in sleep");

  cov_sleep: cover property (mode_r == MODE_WAKE ##1 mode_r == MODE_SLEEP);
  cov_wake: cover property (mode_r == MODE_SLEEP ##1 mode_r == MODE_WAKE);
  cov_both_pins: cover property (first_act_r && second_act_r);
  cov_gate: cover property (gate_err_r ##1 !gate_err_r);

endmodule // erasc_ctrl

// >>> rtl/erasc_pkg.sv
package erasc_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned BASE_PERIOD_US = 1250;
  localparam int unsigned BASE_CYCLES_DEF = BASE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned STEP_SHORT_US = 320000;
  localparam int unsigned STEP_LONG_US = 640000;
  localparam logic [10:0] STEP_SHORT_TICKS = 11'(STEP_SHORT_US / BASE_PERIOD_US);
  localparam logic [10:0] STEP_LONG_TICKS = 11'(STEP_LONG_US / BASE_PERIOD_US);
  localparam logic [3:0] EXP_LONG = 4'h9;

  // event source positions
  localparam int SRC_W = 11;
  localparam int IDX_SAMPLE_READY = 0;
  localparam int IDX_ACCEL_MAG = 1;
  localparam int IDX_FALL_MOTION = 2;
  localparam int IDX_TAP = 3;
  localparam int IDX_ORIENT = 4;
  localparam int IDX_TRANSIENT = 5;
  localparam int IDX_BUFFER = 6;
  localparam int IDX_SLEEPWAKE = 7;
  localparam int IDX_MAGNETIC = 8;
  localparam int IDX_MAG_MAGNITUDE = 9;
  localparam int IDX_MAG_THRESHOLD = 10;
  localparam logic [SRC_W-1:0] RESTART_MASK = 11'h77e;
  localparam logic [SRC_W-1:0] WAKE_MASK = 11'h73e;

  // register indices, byte address is four times the index
  localparam int ADDR_W = 12;
  localparam logic [7:0] REG_SYSTEM_MODE = 8'h0b;
  localparam logic [7:0] REG_INT_SOURCE = 8'h0c;
  localparam logic [7:0] REG_SLEEP_COUNT = 8'h29;
  localparam logic [7:0] REG_PRIMARY = 8'h2a;
  localparam logic [7:0] REG_SECONDARY = 8'h2b;
  localparam logic [7:0] REG_WAKE_ENABLE = 8'h2c;
  localparam logic [7:0] REG_INT_ENABLE = 8'h2d;
  localparam logic [7:0] REG_PIN_ROUTING = 8'h2e;
  localparam logic [7:0] REG_MAG_THS_CFG = 8'h52;
  localparam logic [7:0] REG_MODE_CFG = 8'h5b;
  localparam logic [7:0] REG_MAG_VEC_CFG = 8'h69;
  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions
  localparam int PRI_WAKE_RATE_LSB = 3;
  localparam int PRI_SLEEP_RATE_LSB = 6;
  localparam int SEC_SLEEP_EN_BIT = 2;
  localparam int WK_GATE_BIT = 7;
  localparam int WK_TRANS_BIT = 6;
  localparam int WK_ORIENT_BIT = 5;
  localparam int WK_TAP_BIT = 4;
  localparam int WK_FALL_BIT = 3;
  localparam int WK_AMAG_BIT = 2;
  localparam int WK_POL_BIT = 1;
  localparam int WK_OD_BIT = 0;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_ROUTE_BIT = 1;
  localparam int CFG_WAKE_BIT = 2;
  localparam int MODE_HYBRID_BIT = 7;
  localparam int SM_GATE_ERR_BIT = 7;

  typedef enum logic [1:0] {
    MODE_WAKE = 2'b01,
    MODE_SLEEP = 2'b10
  } erasc_mode_t;

  // rate code 0..7 (800 Hz .. 1.56 Hz) to divide-by-2^n of the 800 Hz base
  function automatic logic [3:0] erasc_rate_exp(input logic [2:0] code);
    logic [3:0] e;
    e = 4'h0;
    unique case (code)
      3'h0: e = 4'h0;
      3'h1: e = 4'h1;
      3'h2: e = 4'h2;
      3'h3: e = 4'h3;
      3'h4: e = 4'h4;
      3'h5: e = 4'h6;
      3'h6: e = 4'h7;
      3'h7: e = 4'h9;
    endcase
    return e;
  endfunction

endpackage

// >>> rtl/erasc_rate_if.sv
`timescale 1ns/10ps
interface erasc_rate_if;
  logic [3:0] rate_exp;
  logic hybrid;
  logic restart;
  logic step;
  logic sample_tick;
  modport ctrl(output rate_exp, hybrid, restart, input step, sample_tick);
  modport timer(input rate_exp, hybrid, restart, output step, sample_tick);
endinterface

// >>> rtl/erasc_rate_timer.sv
`timescale 1ns/10ps
module erasc_rate_timer #(
  parameter int unsigned BASE_CYCLES = erasc_pkg::BASE_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  erasc_rate_if.timer rt
);
  import erasc_pkg::*;

  localparam int BW = $clog2(BASE_CYCLES + 1);
  logic [BW-1:0] base_cnt_r;
  logic [8:0] pre_r;
  logic half_r;
  logic [10:0] step_cnt_r;
  logic step_r;
  logic tick_r;
  logic base_tick;
  logic odr_hit;
  logic [8:0] exp_mask;
  logic [10:0] step_len;

  assign base_tick = base_cnt_r == BW'(BASE_CYCLES - 1);
  assign exp_mask = 9'((10'h001 << rt.rate_exp) - 10'h001);
  assign odr_hit = base_tick && ((pre_r & exp_mask) == 9'h000);
  // hybrid mode interleaves two sensors, so each one sees half the rate
  assign step_len = (rt.rate_exp == EXP_LONG ? STEP_LONG_TICKS :
                     STEP_SHORT_TICKS) << rt.hybrid;

  always_ff @(posedge clk_i) begin
    if (reset_i || base_tick) begin
      base_cnt_r <= '0;
    end else begin
      base_cnt_r <= base_cnt_r + BW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_r <= 9'h000;
      half_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= odr_hit && (!rt.hybrid || half_r);
      if (base_tick) begin
        pre_r <= pre_r + 9'h001;
      end
      if (odr_hit) begin
        half_r <= !half_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || rt.restart) begin
      step_cnt_r <= 11'h000;
      step_r <= 1'b0;
    end else if (base_tick) begin
      step_r <= step_cnt_r == step_len - 11'h001;
      if (step_cnt_r == step_len - 11'h001) begin
        step_cnt_r <= 11'h000;
      end else begin
        step_cnt_r <= step_cnt_r + 11'h001;
      end
    end else begin
      step_r <= 1'b0;
    end
  end

  assign rt.step = step_r;
  assign rt.sample_tick = tick_r;

endmodule // erasc_rate_timer

// >>> bench/erasc_host.sv
`timescale 1ns/10ps
module erasc_host (
  input wire logic clk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic fifo_empty_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
    fifo_empty_o = 1'b1;
  end

  // an access that never sees pready gives up after 16 cycles
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic e, output logic ok);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= {2'h0, idx, 2'h0};
    pwdata_o <= {24'h0, d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_i);
      ok = (pready_i === 1'b1);
    end
    q = prdata_i[7:0];
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // the buffer only reads empty once the host has drained it
  task automatic hold_data(input logic empty);
    @(posedge clk_i);
    fifo_empty_o <= empty;
  endtask
endmodule // erasc_host

// >>> bench/event_routing_autosleep_ctrl_tb.sv
`timescale 1ns/10ps
module event_routing_autosleep_ctrl_tb;
  import erasc_pkg::*;
  localparam int STEP = 256 * 4;
  logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, fifo_empty;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [SRC_W-1:0] evt, run;
  logic p1, p1_oe, p2, p2_oe, sleep, tick, blk, pol;
  logic [3:0] rexp;
  logic [7:0] en_m, rt_m;
  logic [1:0] th_m, vm_m;
  int errors, n_compared, c;

  erasc_host host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .fifo_empty_o(fifo_empty));

  erasc_ctrl #(.BASE_CYCLES(4)) uut (.CLK_I(clk_i), .RESET_I(reset_i),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .EVT_FLAG_I(evt), .FIFO_EMPTY_I(fifo_empty),
    .IRQ_PIN_FIRST_O(p1), .IRQ_PIN_FIRST_OE_O(p1_oe),
    .IRQ_PIN_SECOND_O(p2), .IRQ_PIN_SECOND_OE_O(p2_oe), .SLEEP_O(sleep),
    .RATE_EXP_O(rexp), .SAMPLE_TICK_O(tick), .FUNC_RUN_O(run),
    .FIFO_BLOCK_O(blk));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // pin model: {first active, second active}
  function automatic logic [1:0] want(input logic [10:0] f);
    logic a1, a2;
    a1 = 1'b0;
    a2 = 1'b0;
    for (int i = 0; i < 7; i++) begin
      a1 |= f[i] & en_m[i] & rt_m[i];
      a2 |= f[i] & en_m[i] & ~rt_m[i];
    end
    a1 |= (f[10] & th_m[0] & th_m[1]) | (f[9] & vm_m[0] & vm_m[1]);
    a2 |= (f[10] & th_m[0] & ~th_m[1]) | (f[9] & vm_m[0] & ~vm_m[1]);
    return {a1, a2};
  endfunction

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [7:0] xq,
                     input logic xe);
    logic [7:0] q;
    logic e;
    logic ok;
    host.xfer(w, idx, d, q, e, ok);
    if (!ok) begin
      errors++;
      complete_run();
    end
    check({e, w ? xq : q}, {xe, xq});
  endtask

  task automatic step_evt(input logic [10:0] v);
    @(posedge clk_i);
    evt <= v;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic chk_pins();
    logic [1:0] a;
    a = want(evt);
    check({p1, p1_oe, p2, p2_oe}, {a[1] ~^ pol, 1'b1, a[0] ~^ pol, 1'b1});
  endtask

  task automatic wait_mode(input logic lvl);
    c = 0;
    while (sleep !== lvl && c < 3 * STEP) begin
      @(posedge clk_i);
      c++;
    end
    if (sleep !== lvl) begin
      errors++;
      complete_run();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  initial begin
    reset_i = 1'b1;
    evt = '0;
    {en_m, rt_m, th_m, vm_m, pol} = '0;
    errors = 0;
    n_compared = 0;
    void'($urandom(32924));
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check({p1, p1_oe, p2, p2_oe, sleep, blk, rexp}, 10'h3c0);
    check(run, 11'h7ff);
    bus(1'b0, REG_SLEEP_COUNT, 8'h00, 8'h00, 1'b0);
    bus(1'b1, REG_SLEEP_COUNT, 8'h5a, 8'h00, 1'b0);
    bus(1'b0, REG_SLEEP_COUNT, 8'h00, 8'h5a, 1'b0);
    bus(1'b0, 8'h01, 8'h00, 8'h00, 1'b1);
    en_m = 8'h7f;
    rt_m = 8'($urandom);
    bus(1'b1, REG_INT_ENABLE, en_m, 8'h00, 1'b0);
    bus(1'b1, REG_PIN_ROUTING, rt_m, 8'h00, 1'b0);
    for (int i = 0; i < 7; i++) begin
      step_evt(11'(1 << i));
      chk_pins();
    end
    repeat (6) begin
      step_evt(11'($urandom) & 11'h07f);
      chk_pins();
      bus(1'b0, REG_INT_SOURCE, 8'h00, evt[7:0] & en_m, 1'b0);
    end
    en_m = 8'h00;
    bus(1'b1, REG_INT_ENABLE, en_m, 8'h00, 1'b0);
    step_evt(11'h07f);
    chk_pins();
    for (int r = 0; r < 2; r++) begin
      th_m = {r[0], 1'b1};
      vm_m = {~r[0], 1'b1};
      bus(1'b1, REG_MAG_THS_CFG, {6'h0, th_m}, 8'h00, 1'b0);
      bus(1'b1, REG_MAG_VEC_CFG, {6'h0, vm_m}, 8'h00, 1'b0);
      step_evt(11'h400);
      chk_pins();
      step_evt(11'h200);
      chk_pins();
    end
    pol = 1'b1;
    bus(1'b1, REG_WAKE_ENABLE, 8'h02, 8'h00, 1'b0);
    // the new polarity reaches the pins one edge after the write lands
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk_pins();
    step_evt(11'h000);
    chk_pins();
    // sample-ready stays high throughout: it must not hold off sleep
    step_evt(11'h001);
    en_m = 8'h81;
    rt_m = 8'h80;
    bus(1'b1, REG_INT_ENABLE, en_m, 8'h00, 1'b0);
    bus(1'b1, REG_PIN_ROUTING, rt_m, 8'h00, 1'b0);
    bus(1'b1, REG_PRIMARY, 8'hc0, 8'h00, 1'b0);
    bus(1'b1, REG_SLEEP_COUNT, 8'h02, 8'h00, 1'b0);
    bus(1'b1, REG_WAKE_ENABLE, 8'hc0, 8'h00, 1'b0);
    host.hold_data(1'b0);
    bus(1'b1, REG_SECONDARY, 8'h04, 8'h00, 1'b0);
    wait_mode(1'b1);
    check(c > 2 * STEP - 8 && c <= 2 * STEP + 16, 1'b1);
    @(negedge clk_i);
    check({rexp, blk, p1, p2}, {4'h9, 3'b100});
    check(run[0], 1'b1);
    bus(1'b0, REG_SYSTEM_MODE, 8'h00, 8'h82, 1'b0);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check(p1, 1'b1);
    step_evt(11'h021);
    repeat (40) @(posedge clk_i);
    check(sleep, 1'b1);
    en_m = 8'hc1;
    bus(1'b1, REG_INT_ENABLE, en_m, 8'h00, 1'b0);
    step_evt(11'h061);
    repeat (40) @(posedge clk_i);
    check(sleep, 1'b1);
    en_m = 8'he1;
    bus(1'b1, REG_INT_ENABLE, en_m, 8'h00, 1'b0);
    wait_mode(1'b0);
    check(c <= 4, 1'b1);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check({rexp, blk, run}, {4'h0, 1'b1, 11'h7ff});
    host.hold_data(1'b1);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check(blk, 1'b0);
    repeat (2 * STEP + 100) @(posedge clk_i);
    check(sleep, 1'b0);
    // wake rate 800 Hz: one sample per base period of 4 clocks
    c = 0;
    repeat (40) begin
      @(negedge clk_i);
      c += int'(tick);
    end
    check(c, 10);
    bus(1'b1, REG_MODE_CFG, 8'h80, 8'h00, 1'b0);
    repeat (4) @(posedge clk_i);
    c = 0;
    repeat (40) begin
      @(negedge clk_i);
      c += int'(tick);
    end
    check(c, 5);
    complete_run();
  end
endmodule // event_routing_autosleep_ctrl_tb
